// ---- logic/ostf_framer.sv ----
// Optical status telemetry framer with gate command, lockout and clamp bypass timing
//
// Implementation choices: the placing of the registers and the APB register port.
`timescale 1ns/100ps
module ostf_framer #(
	parameter int unsigned LOCKOUT_CYCLES = ostf_pkg::LOCKOUT_CYC
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic command_light,
	input wire ostf_pkg::ostf_fault_t faults,
	input wire logic clamp_active,
	input wire logic [11:0] link_voltage_sample,
	input wire logic link_voltage_strobe,
	input wire logic [11:0] board_temp_sample,
	input wire logic board_temp_strobe,
	input wire logic [11:0] ext_temp_sample,
	input wire logic ext_temp_strobe,
	input wire logic ext_sensor_missing,
	output logic status_light_output,
	output logic gate_on,
	output logic clamp_bypass,
	output logic pulldown_enable
);
	import ostf_pkg::*;

	ostf_state_t state_q;
	ostf_packet_t pkt_q;
	logic tx_en_q;
	logic [15:0] bitdiv_q;
	logic [15:0] gap_len_q;
	logic [15:0] bit_cnt_q;
	logic [15:0] gap_cnt_q;
	logic [3:0] bit_idx_q;
	logic [2:0] frame_idx_q;
	logic [8:0] frame_sh_q;
	logic [5:0] seq_q;
	logic seq_restart_q;
	logic light_q;
	logic desat_prev_q;
	logic cmd_prev_q;
	logic gate_q;
	logic bypass_q;
	logic pulldown_q;
	logic [19:0] lock_cnt_q;
	logic [15:0] bypass_cnt_q;
	logic [11:0] link_q;
	logic [11:0] board_temp_q;
	logic [11:0] ext_temp_q;
	logic [31:0] prdata_q;
	logic pready_q;
	logic pslverr_q;
	logic tick;
	logic desat_rise;
	logic gap_done;
	logic start_pkt;
	logic blocking;
	logic [11:0] status_word;
	logic [5:0] seq_eff;
	logic [2:0] sel_d;
	logic [11:0] payload_d;
	ostf_packet_t pkt_d;
	logic apb_access;
	logic apb_done;

	function automatic logic [8:0] frame_bits(input ostf_packet_t p, input logic [2:0] idx, input logic sc);
		logic [5:0] d;
		d = ostf_frame_data(p, idx);
		// Light levels after the start bit: inverted data, fault, parity, stop light on
		return {1'b1, ~(^{sc, d}), ~sc, ~d};
	endfunction

	assign tick = (bit_cnt_q == 16'h0000);
	assign desat_rise = faults.desat && !desat_prev_q;
	assign gap_done = (gap_cnt_q == 16'h0000) && tick;
	assign blocking = (lock_cnt_q != 20'h00000);
	assign apb_access = psel && penable;
	assign apb_done = apb_access && pready_q;

	// Status word layout
	always_comb begin
		status_word = 12'h000;
		status_word[7] = blocking;
		status_word[6] = faults.desat || faults.uvlo_pos || faults.uvlo_neg;
		status_word[5] = faults.selftest_fail;
		status_word[4] = command_light;
		status_word[3] = faults.uvlo_pos;
		status_word[2] = faults.uvlo_neg;
		status_word[1] = faults.vge_hi;
		status_word[0] = faults.vge_lo;
	end

	// Packet start and payload selection
	always_comb begin
		start_pkt = 1'b0;
		if (state_q == ST_GAP && tx_en_q) begin
			start_pkt = gap_done || desat_rise;
		end
		seq_eff = (desat_rise || seq_restart_q) ? 6'h00 : seq_q;
		case (seq_eff)
			SEQ_BOARD: begin
				sel_d = SEL_BOARD_TEMP;
				payload_d = board_temp_q;
			end
			SEQ_EXT: begin
				sel_d = SEL_EXT_TEMP;
				payload_d = ext_temp_q;
			end
			default: begin
				sel_d = SEL_STATUS;
				payload_d = status_word;
			end
		endcase
		pkt_d.link_voltage_value = link_q;
		pkt_d.payload_word = payload_d;
		pkt_d.sel = sel_d;
		pkt_d.crc = ostf_crc3({sel_d, payload_d, link_q});
	end

	// Fault rising mid-packet restarts the sequence at the next packet
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			seq_restart_q <= 1'b0;
		end else if (desat_rise && !start_pkt) begin
			seq_restart_q <= 1'b1;
		end else if (start_pkt) begin
			seq_restart_q <= 1'b0;
		end
	end

	// Measurement holding registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			link_q <= 12'h000;
			board_temp_q <= 12'h000;
			ext_temp_q <= 12'h000;
		end else begin
			if (link_voltage_strobe) begin
				link_q <= link_voltage_sample;
			end
			if (board_temp_strobe) begin
				board_temp_q <= board_temp_sample;
			end
			if (ext_sensor_missing) begin
				ext_temp_q <= TEMP_NEG_FULL_SCALE;
			end else if (ext_temp_strobe) begin
				ext_temp_q <= ext_temp_sample;
			end
		end
	end

	// Bit timer, restarted at each packet start
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bit_cnt_q <= 16'h0000;
		end else if (start_pkt || tick) begin
			bit_cnt_q <= (bitdiv_q == 16'h0000) ? 16'h0000 : bitdiv_q - 16'h0001;
		end else begin
			bit_cnt_q <= bit_cnt_q - 16'h0001;
		end
	end

	// Packet and frame sequencer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= ST_GAP;
			pkt_q <= '0;
			gap_cnt_q <= GAP_RST;
			bit_idx_q <= 4'h0;
			frame_idx_q <= 3'h0;
			frame_sh_q <= 9'h1ff;
			seq_q <= 6'h00;
			light_q <= 1'b1;
			desat_prev_q <= 1'b0;
		end else begin
			desat_prev_q <= faults.desat;
			case (state_q)
				ST_GAP: begin
					light_q <= 1'b1;
					if (start_pkt) begin
						pkt_q <= pkt_d;
						seq_q <= seq_eff + 6'h01;
						frame_sh_q <= frame_bits(pkt_d, 3'h0, faults.desat);
						light_q <= 1'b0;
						bit_idx_q <= 4'h0;
						frame_idx_q <= 3'h0;
						state_q <= ST_FRAME;
					end else if (tick && gap_cnt_q != 16'h0000) begin
						gap_cnt_q <= gap_cnt_q - 16'h0001;
					end
				end
				ST_FRAME: begin
					if (tick) begin
						if (bit_idx_q != FRAME_LAST_BIT) begin
							light_q <= frame_sh_q[0];
							frame_sh_q <= {1'b1, frame_sh_q[8:1]};
							bit_idx_q <= bit_idx_q + 4'h1;
						end else if (frame_idx_q != FRAME_LAST) begin
							frame_sh_q <= frame_bits(pkt_q, frame_idx_q + 3'h1, faults.desat);
							light_q <= 1'b0;
							bit_idx_q <= 4'h0;
							frame_idx_q <= frame_idx_q + 3'h1;
						end else begin
							light_q <= 1'b1;
							gap_cnt_q <= gap_len_q;
							state_q <= ST_GAP;
						end
					end
				end
				default: begin
					state_q <= ST_GAP;
				end
			endcase
		end
	end

	// Gate command and lockout
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lock_cnt_q <= 20'h00000;
			cmd_prev_q <= 1'b0;
			gate_q <= 1'b0;
		end else begin
			cmd_prev_q <= command_light;
			if (faults.desat || faults.uvlo_pos || faults.uvlo_neg) begin
				lock_cnt_q <= LOCKOUT_CYCLES[19:0];
			end else if (blocking) begin
				lock_cnt_q <= lock_cnt_q - 20'h00001;
			end
			if (!command_light || blocking || faults.desat || faults.uvlo_pos || faults.uvlo_neg) begin
				gate_q <= 1'b0;
			end else if (!cmd_prev_q) begin
				gate_q <= 1'b1;
			end
		end
	end

	// Clamp bypass after turn-off and pull-down release
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bypass_cnt_q <= 16'h0000;
			bypass_q <= 1'b0;
			pulldown_q <= 1'b1;
		end else begin
			if (gate_q) begin
				bypass_cnt_q <= BYPASS_CYC[15:0];
			end else if (bypass_cnt_q != 16'h0000) begin
				bypass_cnt_q <= bypass_cnt_q - 16'h0001;
			end
			bypass_q <= gate_q || (bypass_cnt_q > 16'h0001);
			pulldown_q <= !gate_q && !clamp_active;
		end
	end

	// APB slave, answers one cycle into the access phase
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= 32'h00000000;
		end else begin
			pready_q <= apb_access && !pready_q;
			pslverr_q <= 1'b0;
			prdata_q <= 32'h00000000;
			if (apb_access && !pready_q) begin
				case (paddr)
					ADDR_CTRL: prdata_q[CTRL_TX_EN_BIT] <= tx_en_q;
					ADDR_BITDIV: prdata_q[15:0] <= bitdiv_q;
					ADDR_GAP: prdata_q[15:0] <= gap_len_q;
					ADDR_STATUS: begin
						prdata_q[11:0] <= status_word;
						prdata_q[STATUS_DESAT_BIT] <= faults.desat;
						pslverr_q <= pwrite;
					end
					ADDR_LINK: begin
						prdata_q[11:0] <= link_q;
						pslverr_q <= pwrite;
					end
					default: pslverr_q <= 1'b1;
				endcase
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_en_q <= CTRL_TX_EN_RST;
			bitdiv_q <= BITDIV_RST;
			gap_len_q <= GAP_RST;
		end else if (apb_done && pwrite) begin
			case (paddr)
				ADDR_CTRL: tx_en_q <= pwdata[CTRL_TX_EN_BIT];
				ADDR_BITDIV: bitdiv_q <= pwdata[15:0];
				ADDR_GAP: gap_len_q <= pwdata[15:0];
				default: tx_en_q <= tx_en_q;
			endcase
		end
	end

	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign status_light_output = light_q;
	assign gate_on = gate_q;
	assign clamp_bypass = bypass_q;
	assign pulldown_enable = pulldown_q;

	a_idle_light_on: assert property (@(posedge pclk) disable iff (!presetn)
		(state_q == ST_GAP && !start_pkt) |=> light_q)
		else $error("line not light on during idle");
	a_start_bit_fall: assert property (@(posedge pclk) disable iff (!presetn)
		(state_q == ST_FRAME && bit_idx_q == 4'h0) |-> !light_q)
		else $error("light on during start bit");
	a_even_parity: assert property (@(posedge pclk) disable iff (!presetn)
		(state_q == ST_FRAME && bit_idx_q == 4'h0) |-> (^(~frame_sh_q[7:0]) == 1'b0))
		else $error("frame parity not even");
	a_stop_light: assert property (@(posedge pclk) disable iff (!presetn)
		(state_q == ST_FRAME && bit_idx_q == FRAME_LAST_BIT) |-> light_q)
		else $error("stop bit not light on");
	a_lockout_gate: assert property (@(posedge pclk) disable iff (!presetn)
		blocking |=> !gate_q)
		else $error("gate on during lockout");
	a_turn_off_cmd: assert property (@(posedge pclk) disable iff (!presetn)
		!command_light |=> !gate_q)
		else $error("gate on without command");
	a_bypass_hold: assert property (@(posedge pclk) disable iff (!presetn)
		$fell(gate_q) |-> bypass_q [*8])
		else $error("bypass dropped early after turn-off");
	a_pulldown_off: assert property (@(posedge pclk) disable iff (!presetn)
		clamp_active |=> !pulldown_q)
		else $error("pull-down on while clamping");
	a_fault_cut_gap: assert property (@(posedge pclk) disable iff (!presetn)
		(state_q == ST_GAP && tx_en_q && desat_rise) |=> (state_q == ST_FRAME && pkt_q.sel == SEL_STATUS))
		else $error("fault did not start status packet");
	a_crc_match: assert property (@(posedge pclk) disable iff (!presetn)
		(state_q == ST_FRAME) |-> pkt_q.crc == ostf_crc3({pkt_q.sel, pkt_q.payload_word, pkt_q.link_voltage_value}))
		else $error("packet crc mismatch");
	a_missing_sensor: assert property (@(posedge pclk) disable iff (!presetn)
		ext_sensor_missing |=> ext_temp_q == TEMP_NEG_FULL_SCALE)
		else $error("missing sensor not full scale");
	a_fault_bit: assert property (@(posedge pclk) disable iff (!presetn)
		(state_q == ST_GAP && start_pkt) |=> frame_sh_q[6] == !$past(faults.desat))
		else $error("fault bit wrong");
	a_lockout_flag: assert property (@(posedge pclk) disable iff (!presetn)
		(faults.desat || faults.uvlo_pos || faults.uvlo_neg) |=> blocking)
		else $error("lockout flag not set by fault");
	a_gate_turn_on: assert property (@(posedge pclk) disable iff (!presetn)
		(command_light && !cmd_prev_q && !blocking && !status_word[6]) |=> gate_q)
		else $error("gate not on after command");
	a_bypass_release: assert property (@(posedge pclk) disable iff (!presetn)
		(!gate_q && bypass_cnt_q == 16'h0000) |=> !bypass_q)
		else $error("bypass held after timeout");

endmodule

// ---- logic/ostf_pkg.sv ----
// Constants, types and helper functions for the optical status telemetry framer
package ostf_pkg;

	// Timing at the 50 MHz pclk
	localparam int unsigned CLK_PERIOD_NS = 20;
	localparam int unsigned BYPASS_MIN_NS = 15000;
	localparam int unsigned BYPASS_CYC = (BYPASS_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned LOCKOUT_MS = 20;
	localparam int unsigned LOCKOUT_CYC = LOCKOUT_MS * 1000000 / CLK_PERIOD_NS;

	// Register byte addresses
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_BITDIV = 8'h04;
	localparam logic [7:0] ADDR_GAP = 8'h08;
	localparam logic [7:0] ADDR_STATUS = 8'h0c;
	localparam logic [7:0] ADDR_LINK = 8'h10;

	// Field positions and reset values
	localparam int unsigned CTRL_TX_EN_BIT = 0;
	localparam int unsigned STATUS_DESAT_BIT = 12;
	localparam logic CTRL_TX_EN_RST = 1'b1;
	localparam logic [15:0] BITDIV_RST = 16'h0019;
	localparam logic [15:0] GAP_RST = 16'h000a;

	// Framing
	localparam logic [3:0] FRAME_LAST_BIT = 4'h9;
	localparam logic [2:0] FRAME_LAST = 3'h4;
	localparam logic [5:0] SEQ_BOARD = 6'h1f;
	localparam logic [5:0] SEQ_EXT = 6'h3f;
	localparam logic [2:0] SEL_STATUS = 3'h7;
	localparam logic [2:0] SEL_EXT_TEMP = 3'h5;
	localparam logic [2:0] SEL_BOARD_TEMP = 3'h6;
	localparam logic [11:0] TEMP_NEG_FULL_SCALE = 12'h000;
	localparam logic [2:0] CRC_INIT = 3'h0;
	localparam logic [2:0] CRC_POLY_REFL = 3'h6;

	typedef enum logic {ST_GAP, ST_FRAME} ostf_state_t;

	typedef struct packed {
		logic desat;
		logic uvlo_pos;
		logic uvlo_neg;
		logic vge_hi;
		logic vge_lo;
		logic selftest_fail;
	} ostf_fault_t;

	typedef struct packed {
		logic [11:0] link_voltage_value;
		logic [11:0] payload_word;
		logic [2:0] sel;
		logic [2:0] crc;
	} ostf_packet_t;

	// Reflected x^3+x+1, fields taken LSB first in order link, payload, selector
	function automatic logic [2:0] ostf_crc3(input logic [26:0] bits);
		logic [2:0] c;
		logic fb;
		c = CRC_INIT;
		for (int i = 0; i < 27; i++) begin
			fb = c[0] ^ bits[i];
			c = {1'b0, c[2:1]};
			if (fb) begin
				c = c ^ CRC_POLY_REFL;
			end
		end
		return c;
	endfunction

	function automatic logic [5:0] ostf_frame_data(input ostf_packet_t p, input logic [2:0] idx);
		case (idx)
			3'h0: return p.link_voltage_value[5:0];
			3'h1: return p.link_voltage_value[11:6];
			3'h2: return p.payload_word[5:0];
			3'h3: return p.payload_word[11:6];
			default: return {p.sel, p.crc};
		endcase
	endfunction

endpackage

// ---- verification/ostf_ctrl_model.sv ----
// External controller model: command light driver and status frame receiver
`timescale 1ns/100ps
module ostf_ctrl_model #(
	parameter int BIT_CYC = 4
) (
	input wire logic pclk,
	input wire logic light,
	input wire logic cmd_req,
	output logic command_light,
	output logic fr_valid,
	output logic fr_first,
	output logic [5:0] fr_data,
	output logic fr_des,
	output logic fr_ok
);
	int idle;
	logic [9:0] l;

	initial begin
		command_light = 1'b0;
		idle = 0;
		fr_valid = 1'b0;
		fr_first = 1'b0;
		fr_data = 6'h00;
		fr_des = 1'b0;
		fr_ok = 1'b0;
	end

	// Light level follows the command request one cycle later
	always @(posedge pclk) begin
		command_light <= cmd_req;
		idle <= light ? idle + 1 : 0;
	end

	// Mid-bit sampling; a long idle before a start marks a packet's first frame
	initial begin
		forever begin
			@(negedge light);
			fr_first <= (idle > 10 * BIT_CYC);
			repeat (BIT_CYC / 2) @(posedge pclk);
			l[0] = light;
			for (int i = 1; i < 10; i++) begin
				repeat (BIT_CYC) @(posedge pclk);
				l[i] = light;
			end
			fr_data <= ~l[6:1];
			fr_des <= ~l[7];
			fr_ok <= !l[0] && l[9] && !(^(~l[8:1]));
			fr_valid <= 1'b1;
			@(posedge pclk);
			fr_valid <= 1'b0;
		end
	end
endmodule

// ---- verification/ostf_framer_tb.sv ----
// Self-checking testbench for the optical status telemetry framer
`timescale 1ns/100ps
module ostf_framer_tb;
	import ostf_pkg::*;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, command_light, clamp_active;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, r;
	logic e, ok, lv_stb, bt_stb, et_stb, ext_missing, light, gate_on, clamp_bypass, pulldown_enable;
	logic cmd_req, fr_valid, fr_first, fr_des, fr_ok, fdes;
	logic [5:0] fr_data;
	logic [5:0] fd [0:4];
	logic [11:0] lv, bt, et, lk, py;
	logic [2:0] q_sel [0:63];
	logic [11:0] q_pay [0:63];
	logic q_des [0:63];
	ostf_fault_t faults;
	int err_count, check_count, fi, pk_n, n0;

	ostf_framer #(.LOCKOUT_CYCLES(50)) uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.command_light(command_light), .faults(faults), .clamp_active(clamp_active),
		.link_voltage_sample(lv), .link_voltage_strobe(lv_stb), .board_temp_sample(bt),
		.board_temp_strobe(bt_stb), .ext_temp_sample(et), .ext_temp_strobe(et_stb),
		.ext_sensor_missing(ext_missing), .status_light_output(light), .gate_on(gate_on),
		.clamp_bypass(clamp_bypass), .pulldown_enable(pulldown_enable));

	ostf_ctrl_model #(.BIT_CYC(4)) ctrl (.pclk(pclk), .light(light), .cmd_req(cmd_req),
		.command_light(command_light), .fr_valid(fr_valid), .fr_first(fr_first), .fr_data(fr_data),
		.fr_des(fr_des), .fr_ok(fr_ok));

	initial begin
		pclk = 1'b0;
		forever #10 pclk = ~pclk;
	end

	function automatic logic [2:0] crc3(input logic [26:0] v);
		logic [2:0] c;
		c = 3'h0;
		for (int i = 0; i < 27; i++) begin
			c = (c[0] ^ v[i]) ? ({1'b0, c[2:1]} ^ 3'h6) : {1'b0, c[2:1]};
		end
		return c;
	endfunction

	task automatic chk(input logic [31:0] ex, input logic [31:0] got);
		check_count++;
		if (got !== ex) begin
			err_count++;
			$display("ERROR t=%0t exp=%h got=%h", $time, ex, got);
		end
	endtask

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic conclude();
		$display("checks %0d mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	// Packet assembly from received frames
	always @(posedge pclk) begin
		if (fr_valid) begin
			if (fr_first || fi == 5) begin
				fi = 0;
			end
			chk(1, fr_ok);
			fd[fi] = fr_data;
			if (fi == 0) begin
				fdes = fr_des;
			end
			if (fi == 4) begin
				lk = {fd[1], fd[0]};
				py = {fd[3], fd[2]};
				chk(12'h9c4, lk);
				chk(crc3({fd[4][5:3], py, lk}), fd[4][2:0]);
				if (pk_n < 64) begin
					q_sel[pk_n] = fd[4][5:3];
					q_pay[pk_n] = py;
					q_des[pk_n] = fdes;
				end
				pk_n++;
			end
			fi++;
		end
	end

	initial begin
		#1200000;
		err_count++;
		conclude();
	end

	initial begin
		{presetn, psel, penable, pwrite, clamp_active, lv_stb, bt_stb, et_stb, cmd_req} = '0;
		{paddr, pwdata, lv, bt, et} = '0;
		faults = '0;
		ext_missing = 1'b1;
		err_count = 0;
		check_count = 0;
		fi = 0;
		pk_n = 0;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		@(negedge pclk);
		chk(1, light);
		chk(0, gate_on);
		chk(1, pulldown_enable);
		apb(0, ADDR_CTRL, 0);
		chk(1, r);
		apb(0, ADDR_BITDIV, 0);
		chk(BITDIV_RST, r);
		apb(1, ADDR_BITDIV, 32'h00000004);
		apb(0, ADDR_GAP, 0);
		chk(GAP_RST, r);
		apb(0, 8'h20, 0);
		chk(1, e);
		chk(0, r);
		apb(1, ADDR_LINK, 32'h00000123);
		chk(1, e);
		lv <= 12'h9c4;
		bt <= 12'h154;
		et <= 12'h118;
		{lv_stb, bt_stb, et_stb} <= 3'h7;
		@(posedge pclk);
		{lv_stb, bt_stb, et_stb} <= 3'h0;
		apb(0, ADDR_LINK, 0);
		chk(12'h9c4, r);
		$display("registers done");
		faults <= 6'b001111;
		apb(0, ADDR_STATUS, 0);
		chk(6'b100111, r[5:0]);
		faults <= '0;
		repeat (80) @(posedge pclk);
		apb(0, ADDR_STATUS, 0);
		chk(0, r[7:0]);
		$display("status done");
		cmd_req <= 1'b1;
		repeat (4) @(posedge pclk);
		chk(3'b110, {gate_on, clamp_bypass, pulldown_enable});
		cmd_req <= 1'b0;
		repeat (4) @(posedge pclk);
		chk(0, gate_on);
		repeat (730) @(posedge pclk);
		chk(1, clamp_bypass);
		repeat (280) @(posedge pclk);
		chk(2'b01, {clamp_bypass, pulldown_enable});
		clamp_active <= 1'b1;
		repeat (3) @(posedge pclk);
		chk(0, pulldown_enable);
		clamp_active <= 1'b0;
		$display("gate done");
		cmd_req <= 1'b1;
		repeat (4) @(posedge pclk);
		faults.uvlo_pos <= 1'b1;
		repeat (3) @(posedge pclk);
		chk(0, gate_on);
		faults.uvlo_pos <= 1'b0;
		repeat (30) @(posedge pclk);
		apb(0, ADDR_STATUS, 0);
		chk(1, r[7]);
		repeat (40) @(posedge pclk);
		apb(0, ADDR_STATUS, 0);
		chk(2'b00, {r[7], gate_on});
		cmd_req <= 1'b0;
		repeat (3) @(posedge pclk);
		cmd_req <= 1'b1;
		repeat (4) @(posedge pclk);
		chk(1, gate_on);
		cmd_req <= 1'b0;
		repeat (1100) @(posedge pclk);
		$display("lockout done");
		n0 = pk_n;
		while (pk_n == n0) @(posedge pclk);
		repeat (12) @(posedge pclk);
		faults.desat <= 1'b1;
		pk_n = 0;
		ok = 1'b0;
		repeat (5) begin
			@(negedge pclk);
			if (light === 1'b0) ok = 1'b1;
		end
		chk(1, ok);
		repeat (300) @(posedge pclk);
		faults.desat <= 1'b0;
		while (pk_n < 64) @(posedge pclk);
		chk(2'b11, {q_des[0], q_sel[0] == SEL_STATUS});
		for (int i = 3; i < 64; i++) begin
			chk(0, q_des[i]);
			chk(i == 31 ? 3'h6 : (i == 63 ? 3'h5 : 3'h7), q_sel[i]);
			chk(i == 31 ? 12'h154 : 12'h000, q_pay[i]);
		end
		$display("sequence done");
		conclude();
	end
endmodule
